// >>> dld_pkg.sv
// Constants, register map and carrier types of the drive level detector.
// Assumes one 40 MHz clock and 16-bit fixed-point inputs from the drive.
package dld_pkg;

  // Clock and delay tick (delays count in 0.01 s steps)
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned TICK_TIME_NS  = 10_000_000;
  localparam int unsigned TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;

  // Register indexes; byte address is four times the index
  localparam logic [13:0] IDX_DO_SEL   = 14'h0a01;
  localparam logic [13:0] IDX_RLY_SEL  = 14'h0a02;
  localparam logic [13:0] IDX_FRQ_LVL  = 14'h0a19;
  localparam logic [13:0] IDX_FRQ_AMP  = 14'h0a1a;
  localparam logic [13:0] IDX_ZC_LVL   = 14'h0a1d;
  localparam logic [13:0] IDX_ZC_DLY   = 14'h0a1e;
  localparam logic [13:0] IDX_OV_THR   = 14'h0a1f;
  localparam logic [13:0] IDX_OV_DLY   = 14'h0a20;
  localparam logic [13:0] IDX_CR_LVL   = 14'h0a21;
  localparam logic [13:0] IDX_CR_WID   = 14'h0a22;
  localparam logic [13:0] IDX_IRQ_STAT = 14'h0a40;
  localparam logic [13:0] IDX_IRQ_MASK = 14'h0a41;
  localparam logic [13:0] IDX_IND      = 14'h0a42;

  // Reset values (Hz in 0.01, percent in 0.1, time in 0.01 s)
  localparam logic [15:0] RST_DO_SEL  = 16'h0002;
  localparam logic [15:0] RST_RLY_SEL = 16'h0008;
  localparam logic [15:0] RST_FRQ_LVL = 16'h1388;
  localparam logic [15:0] RST_FRQ_AMP = 16'h0000;
  localparam logic [15:0] RST_ZC_LVL  = 16'h0032;
  localparam logic [15:0] RST_ZC_DLY  = 16'h000a;
  localparam logic [15:0] RST_OV_THR  = 16'h07d0;
  localparam logic [15:0] RST_OV_DLY  = 16'h0001;
  localparam logic [15:0] RST_CR_LVL  = 16'h03e8;
  localparam logic [15:0] RST_CR_WID  = 16'h0000;

  // Setting limits
  localparam logic [15:0] LIM_ZERO    = 16'h0000;
  localparam logic [15:0] LIM_PCT100  = 16'h03e8;
  localparam logic [15:0] LIM_PCT300  = 16'h0bb8;
  localparam logic [15:0] LIM_DLY_MIN = 16'h0001;
  localparam logic [15:0] LIM_DLY_MAX = 16'hea60;
  localparam logic [15:0] LIM_SEL_MAX = 16'h0023;
  localparam logic [31:0] PCT_SCALE   = 32'h0000_03e8;

  // Output function codes
  localparam logic [15:0] FN_ZERO_CUR   = 16'h0007;
  localparam logic [15:0] FN_FREQ_REACH = 16'h0016;
  localparam logic [15:0] FN_CUR_REACH  = 16'h0017;
  localparam logic [15:0] FN_OVER_CUR   = 16'h001e;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Configuration set
  typedef struct packed {
    logic [15:0] do_sel;
    logic [15:0] rly_sel;
    logic [15:0] frq_lvl;
    logic [15:0] frq_amp;
    logic [15:0] zc_lvl;
    logic [15:0] zc_dly;
    logic [15:0] ov_thr;
    logic [15:0] ov_dly;
    logic [15:0] cr_lvl;
    logic [15:0] cr_wid;
  } dld_cfg_s;

  // Indications; same layout in status, mask and live register
  typedef struct packed {
    logic over_cur;
    logic cur_reach;
    logic freq_reach;
    logic zero_cur;
  } dld_ind_s;

endpackage : dld_pkg

// >>> dld_top.sv
// Level detection of frequency and current with output routing.
// Assumes AXI4-Lite master, inputs synchronous to mclk, fixed-point
// frequency in 0.01 Hz and current in the drive's own current unit.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/100ps

// Duration qualifier: high once cond has held longer than delay ticks
module dld_qual #(
  parameter int unsigned TICKS = 400000
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        cond,
  input  wire logic [15:0] delay,
  output logic             qual_ff
);
  logic [31:0] pre_ff;
  logic [15:0] tick_ff;
  wire         pre_wrap = (pre_ff == 32'(TICKS - 1));
  wire         elapsed  = (tick_ff > delay) ||
                          ((tick_ff == delay) && (pre_ff != 32'h0));
  // Cycle prescaler and saturating tick count, cleared when cond drops
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pre_ff  <= 32'h0;
      tick_ff <= 16'h0;
      qual_ff <= 1'b0;
    end else if (!cond) begin
      pre_ff  <= 32'h0;
      tick_ff <= 16'h0;
      qual_ff <= 1'b0;
    end else begin
      pre_ff  <= pre_wrap ? 32'h0 : pre_ff + 32'h1;
      if (pre_wrap && tick_ff != 16'hffff)
        tick_ff <= tick_ff + 16'h1;
      qual_ff <= elapsed;
    end
  end
endmodule // dld_qual

// Contract
// - Frequency reached is high while frequency is in level +/- amplitude.
// - A selector holding 22 routes frequency reached to its output.
// - Frequency level resets to 50.00 Hz, range 0 to max frequency.
// - Half-width is max frequency times amplitude, 0.0 to 100.0, reset 0.0.
// - Zero current rises once current stays at or below level past delay.
// - Zero current level resets to 5.0 percent, range 0.0 to 300.0.
// - Zero current delay resets to 0.10 s, range 0.01 to 600.00 s.
// - Over-limit rises once current stays above threshold past delay.
// - A selector holding 30 routes the over-limit indication to its output.
// - Over-limit threshold resets to 200.0, delay 0.01 s in 0 to 600.00 s.
// - Current reached is high within (level +/- width) times rated current.
// - A selector holding 23 routes current reached to its output.
// - Half-width is width times rated current, 0.0 to 300.0, level 100.0.
module dld_top
  import dld_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // AXI4-Lite write channels
  input  wire logic [15:0] s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  // AXI4-Lite read channels
  input  wire logic [15:0] s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  // Drive measurements and settings
  input  wire logic [15:0] op_freq,
  input  wire logic [15:0] out_current,
  input  wire logic [15:0] maximum_output_frequency,
  input  wire logic [15:0] motor_rated_current,
  // Outputs
  output logic             do_out,
  output logic             relay_out,
  output logic             irq
);

  dld_cfg_s    cfg_ff;
  dld_ind_s    ind;
  logic        zero_q, over_q;
  dld_ind_s    ind_dly_ff;
  dld_ind_s    stat_ff;
  dld_ind_s    mask_ff;
  logic [15:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic        awready_ff;
  logic        wready_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        arready_ff;
  logic        rvalid_ff;
  logic [1:0]  rresp_ff;
  logic [31:0] rdata_ff;
  logic        do_ff;
  logic        rly_ff;
  logic        irq_ff;
  logic        freq_reach_ff;
  logic        cur_reach_ff;

  // Merge byte lanes into a 16-bit register
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    merge = {strb[1] ? data[15:8] : old[15:8],
             strb[0] ? data[7:0]  : old[7:0]};
  endfunction

  // Saturate a value into [lo, hi]
  function automatic logic [15:0] clamp(input logic [15:0] v,
                                        input logic [15:0] lo,
                                        input logic [15:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Scale a setting by a base in 0.1 percent
  function automatic logic [31:0] scale(input logic [15:0] base,
                                        input logic [15:0] pct);
    scale = (32'(base) * 32'(pct)) / PCT_SCALE;
  endfunction

  // Function code to indication
  function automatic logic route(input logic [15:0] code,
                                 input dld_ind_s    i);
    case (code)
      FN_ZERO_CUR:   route = i.zero_cur;
      FN_FREQ_REACH: route = i.freq_reach;
      FN_CUR_REACH:  route = i.cur_reach;
      FN_OVER_CUR:   route = i.over_cur;
      default:       route = 1'b0;
    endcase
  endfunction

  // Frequency window around the reach level
  wire [31:0] f_half = scale(maximum_output_frequency,
                             cfg_ff.frq_amp);
  wire [31:0] f_lvl  = 32'(cfg_ff.frq_lvl);
  wire [31:0] f_lo   = (f_lvl > f_half) ? f_lvl - f_half : 32'h0;
  wire [31:0] f_hi   = f_lvl + f_half;
  wire        f_in   = (32'(op_freq) >= f_lo) &&
                       (32'(op_freq) <= f_hi);

  // Current window and thresholds relative to rated current
  wire [31:0] c_cur  = 32'(out_current);
  wire [31:0] c_mid  = scale(motor_rated_current, cfg_ff.cr_lvl);
  wire [31:0] c_half = scale(motor_rated_current, cfg_ff.cr_wid);
  wire [31:0] c_lo   = (c_mid > c_half) ? c_mid - c_half : 32'h0;
  wire [31:0] c_hi   = c_mid + c_half;
  wire        c_in   = (c_cur >= c_lo) && (c_cur <= c_hi);
  wire        zc_cond = c_cur <= scale(motor_rated_current,
                                       cfg_ff.zc_lvl);
  wire        ov_cond = c_cur >  scale(motor_rated_current,
                                       cfg_ff.ov_thr);

  // Write decode
  wire        wr_go   = !awready_ff && !wready_ff && !bvalid_ff;
  wire [13:0] wr_idx  = awaddr_ff[15:2];
  wire        wr_map  = (wr_idx == IDX_DO_SEL)  || (wr_idx == IDX_RLY_SEL) ||
                        (wr_idx == IDX_FRQ_LVL) || (wr_idx == IDX_FRQ_AMP) ||
                        (wr_idx == IDX_ZC_LVL)  || (wr_idx == IDX_ZC_DLY)  ||
                        (wr_idx == IDX_OV_THR)  || (wr_idx == IDX_OV_DLY)  ||
                        (wr_idx == IDX_CR_LVL)  || (wr_idx == IDX_CR_WID)  ||
                        (wr_idx == IDX_IRQ_STAT) || (wr_idx == IDX_IRQ_MASK) ||
                        (wr_idx == IDX_IND);
  wire        wr_stat = wr_go && (wr_idx == IDX_IRQ_STAT) && wstrb_ff[0];

  // Next configuration: merged lanes then saturated into range
  dld_cfg_s   nxt_cfg;
  always_comb begin
    nxt_cfg = cfg_ff;
    if (wr_go) begin
      case (wr_idx)
        IDX_DO_SEL:  nxt_cfg.do_sel  = clamp(merge(cfg_ff.do_sel,
                       wdata_ff, wstrb_ff), LIM_ZERO, LIM_SEL_MAX);
        IDX_RLY_SEL: nxt_cfg.rly_sel = clamp(merge(cfg_ff.rly_sel,
                       wdata_ff, wstrb_ff), LIM_ZERO, LIM_SEL_MAX);
        IDX_FRQ_LVL: nxt_cfg.frq_lvl = clamp(merge(cfg_ff.frq_lvl,
                       wdata_ff, wstrb_ff), LIM_ZERO,
                       maximum_output_frequency);
        IDX_FRQ_AMP: nxt_cfg.frq_amp = clamp(merge(cfg_ff.frq_amp,
                       wdata_ff, wstrb_ff), LIM_ZERO, LIM_PCT100);
        IDX_ZC_LVL:  nxt_cfg.zc_lvl  = clamp(merge(cfg_ff.zc_lvl,
                       wdata_ff, wstrb_ff), LIM_ZERO, LIM_PCT300);
        IDX_ZC_DLY:  nxt_cfg.zc_dly  = clamp(merge(cfg_ff.zc_dly,
                       wdata_ff, wstrb_ff), LIM_DLY_MIN,
                       LIM_DLY_MAX);
        IDX_OV_THR:  nxt_cfg.ov_thr  = clamp(merge(cfg_ff.ov_thr,
                       wdata_ff, wstrb_ff), LIM_ZERO, LIM_PCT300);
        IDX_OV_DLY:  nxt_cfg.ov_dly  = clamp(merge(cfg_ff.ov_dly,
                       wdata_ff, wstrb_ff), LIM_ZERO, LIM_DLY_MAX);
        IDX_CR_LVL:  nxt_cfg.cr_lvl  = clamp(merge(cfg_ff.cr_lvl,
                       wdata_ff, wstrb_ff), LIM_ZERO, LIM_PCT300);
        IDX_CR_WID:  nxt_cfg.cr_wid  = clamp(merge(cfg_ff.cr_wid,
                       wdata_ff, wstrb_ff), LIM_ZERO, LIM_PCT300);
        default:     nxt_cfg = cfg_ff;
      endcase
    end
  end

  // Read decode
  wire [13:0] rd_idx = s_araddr[15:2];
  logic [15:0] rd_val;
  logic        rd_map;
  always_comb begin
    rd_map = 1'b1;
    case (rd_idx)
      IDX_DO_SEL:   rd_val = cfg_ff.do_sel;
      IDX_RLY_SEL:  rd_val = cfg_ff.rly_sel;
      IDX_FRQ_LVL:  rd_val = cfg_ff.frq_lvl;
      IDX_FRQ_AMP:  rd_val = cfg_ff.frq_amp;
      IDX_ZC_LVL:   rd_val = cfg_ff.zc_lvl;
      IDX_ZC_DLY:   rd_val = cfg_ff.zc_dly;
      IDX_OV_THR:   rd_val = cfg_ff.ov_thr;
      IDX_OV_DLY:   rd_val = cfg_ff.ov_dly;
      IDX_CR_LVL:   rd_val = cfg_ff.cr_lvl;
      IDX_CR_WID:   rd_val = cfg_ff.cr_wid;
      IDX_IRQ_STAT: rd_val = {12'h000, stat_ff};
      IDX_IRQ_MASK: rd_val = {12'h000, mask_ff};
      IDX_IND:      rd_val = {12'h000, ind};
      default: begin
        rd_val = 16'h0000;
        rd_map = 1'b0;
      end
    endcase
  end

  // Configuration registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      cfg_ff <= '{RST_DO_SEL, RST_RLY_SEL, RST_FRQ_LVL, RST_FRQ_AMP,
                  RST_ZC_LVL, RST_ZC_DLY, RST_OV_THR, RST_OV_DLY,
                  RST_CR_LVL, RST_CR_WID};
    else
      cfg_ff <= nxt_cfg;
  end

  // Write channel: address and data taken in either order
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
      awaddr_ff  <= 16'h0000;
      wdata_ff   <= 32'h0;
      wstrb_ff   <= 4'h0;
    end else begin
      if (s_awvalid && awready_ff) begin
        awaddr_ff  <= s_awaddr;
        awready_ff <= 1'b0;
      end
      if (s_wvalid && wready_ff) begin
        wdata_ff  <= s_wdata;
        wstrb_ff  <= s_wstrb;
        wready_ff <= 1'b0;
      end
      if (wr_go) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_ff && s_bready) begin
        bvalid_ff  <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff  <= 1'b1;
      end
    end
  end

  // Read channel: data one cycle after the address is taken
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rresp_ff   <= RESP_OKAY;
      rdata_ff   <= 32'h0;
    end else if (s_arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rresp_ff   <= rd_map ? RESP_OKAY : RESP_SLVERR;
      rdata_ff   <= {16'h0000, rd_val};
    end else if (rvalid_ff && s_rready) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
    end
  end

  // Duration-qualified current indications
  dld_qual #(.TICKS(TICK_CYC)) u_zero_qual (
    .mclk    (mclk),
    .rst     (rst),
    .cond    (zc_cond),
    .delay   (cfg_ff.zc_dly),
    .qual_ff (zero_q)
  );
  dld_qual #(.TICKS(TICK_CYC)) u_over_qual (
    .mclk    (mclk),
    .rst     (rst),
    .cond    (ov_cond),
    .delay   (cfg_ff.ov_dly),
    .qual_ff (over_q)
  );
  assign ind = {over_q, cur_reach_ff, freq_reach_ff, zero_q};

  // Window results, routed outputs, sticky status and interrupt
  wire dld_ind_s rise  = ind & ~ind_dly_ff;
  wire dld_ind_s clr   = wr_stat ? wdata_ff[3:0] : 4'h0;
  wire dld_ind_s nxt_stat = (stat_ff & ~clr) | rise;  // set wins over clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      freq_reach_ff <= 1'b0;
      cur_reach_ff  <= 1'b0;
      do_ff         <= 1'b0;
      rly_ff        <= 1'b0;
      ind_dly_ff    <= '0;
      stat_ff       <= '0;
      mask_ff       <= '0;
      irq_ff        <= 1'b0;
    end else begin
      freq_reach_ff <= f_in;
      cur_reach_ff  <= c_in;
      do_ff         <= route(cfg_ff.do_sel, ind);
      rly_ff        <= route(cfg_ff.rly_sel, ind);
      ind_dly_ff    <= ind;
      stat_ff       <= nxt_stat;
      if (wr_go && wr_idx == IDX_IRQ_MASK && wstrb_ff[0])
        mask_ff <= wdata_ff[3:0];
      irq_ff        <= |(nxt_stat & mask_ff);
    end
  end

  // Port drive
  assign s_awready = awready_ff;
  assign s_wready  = wready_ff;
  assign s_bvalid  = bvalid_ff;
  assign s_bresp   = bresp_ff;
  assign s_arready = arready_ff;
  assign s_rvalid  = rvalid_ff;
  assign s_rresp   = rresp_ff;
  assign s_rdata   = rdata_ff;
  assign do_out    = do_ff;
  assign relay_out = rly_ff;
  assign irq       = irq_ff;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_freq_in_win:  assert property (ind.freq_reach |->
    $past(op_freq) >= $past(f_lo[15:0]) || $past(f_lo) > 32'hffff)
    else $error("frequency reached outside window");
  chk_do_freq_sel:  assert property (
    cfg_ff.do_sel == FN_FREQ_REACH && $stable(cfg_ff.do_sel)
    |-> do_out == $past(ind.freq_reach))
    else $error("terminal does not follow frequency reached");
  chk_amp_range:    assert property (cfg_ff.frq_amp <= LIM_PCT100)
    else $error("amplitude above limit");
  chk_zero_qual:    assert property ($rose(ind.zero_cur) |->
    $past(zc_cond) && $past(zc_cond, 2))
    else $error("zero current raised without held condition");
  chk_zc_level:     assert property (cfg_ff.zc_lvl <= LIM_PCT300)
    else $error("zero current level above limit");
  chk_zc_delay:     assert property (cfg_ff.zc_dly >= LIM_DLY_MIN &&
    cfg_ff.zc_dly <= LIM_DLY_MAX)
    else $error("zero current delay out of range");
  chk_over_qual:    assert property ($rose(ind.over_cur) |->
    $past(ov_cond) && $past(ov_cond, 2))
    else $error("over limit raised without held condition");
  chk_rly_over_sel: assert property (
    cfg_ff.rly_sel == FN_OVER_CUR && $stable(cfg_ff.rly_sel)
    |-> relay_out == $past(ind.over_cur))
    else $error("relay does not follow over limit");
  chk_cur_reach:    assert property (c_in |=> ind.cur_reach)
    else $error("current reached missing inside window");
  chk_do_cur_sel:   assert property (
    cfg_ff.do_sel == FN_CUR_REACH && $stable(cfg_ff.do_sel)
    |-> do_out == $past(ind.cur_reach))
    else $error("terminal does not follow current reached");
  chk_sel_range:    assert property (cfg_ff.do_sel <= LIM_SEL_MAX &&
    cfg_ff.rly_sel <= LIM_SEL_MAX)
    else $error("selector out of range");
  chk_qual_drop:    assert property (!ov_cond |=> !ind.over_cur)
    else $error("over limit held after condition ended");

  cov_freq_reach: cover property ($rose(ind.freq_reach));
  cov_zero_cur:   cover property ($rose(ind.zero_cur));
  cov_irq:        cover property ($rose(irq));
  cov_bad_write:  cover property (s_bvalid && s_bresp == RESP_SLVERR);

endmodule // dld_top

// >>> dld_load.sv
// Model of the equipment wired to the digital output and relay.
// Assumes both outputs are synchronous to mclk.
`timescale 1ns/100ps
module dld_load (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Drive outputs
  input  wire logic       do_out,
  input  wire logic       relay_out,
  // Observed state
  output logic            do_on_ff,
  output logic            rly_on_ff,
  output logic [7:0]      pull_cnt_ff
);
  // Loads follow a cycle late; each relay pull-in is counted
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      do_on_ff    <= 1'h0;
      rly_on_ff   <= 1'h0;
      pull_cnt_ff <= 8'h00;
    end else begin
      do_on_ff  <= do_out;
      rly_on_ff <= relay_out;
      if (relay_out && !rly_on_ff) pull_cnt_ff <= pull_cnt_ff + 8'h01;
    end
  end
endmodule // dld_load

// >>> tb_top.sv
// Self-checking bench of the level detector.
// Assumes dld_top with a short delay tick and the dld_load model.
`timescale 1ns/100ps
module tb_top;
  import dld_pkg::*;
  // Stimulus and observed signals
  logic        mclk = 1'h0, rst = 1'h1;
  logic [15:0] s_awaddr = 16'h0, s_araddr = 16'h0;
  logic [31:0] s_wdata = 32'h0, s_rdata, rdv;
  logic [3:0]  s_wstrb = 4'hf;
  logic        s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0;
  logic        s_arvalid = 1'h0, s_rready = 1'h0;
  logic [15:0] op_freq = 16'h0, out_current = 16'h05dc;
  logic [15:0] max_f = 16'h2710, rat_i = 16'h03e8;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic        do_out, relay_out, irq, rly_on;
  logic [1:0]  s_bresp, s_rresp, rsp;
  logic [7:0]  pulls;
  int          fails = 0, tests_run = 0;

  dld_top #(.TICK_CYC(4)) dut_u (.mclk, .rst, .s_awaddr, .s_awvalid,
    .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp,
    .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
    .s_rresp, .s_rvalid, .s_rready, .op_freq, .out_current,
    .maximum_output_frequency(max_f), .motor_rated_current(rat_i),
    .do_out, .relay_out, .irq);
  dld_load ext_u (.mclk, .rst, .do_out, .relay_out, .do_on_ff(),
    .rly_on_ff(rly_on), .pull_cnt_ff(pulls));

  // Clock of 25 ns
  always #12.5 mclk = ~mclk;

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Bus write; valids drop once taken, bready held until the answer
  task automatic wr(input logic [13:0] idx, input logic [15:0] d);
    int n;
    @(posedge mclk);
    s_awaddr <= {idx, 2'h0};
    s_wdata <= {16'h0000, d};
    s_awvalid <= 1'h1;
    s_wvalid <= 1'h1;
    s_bready <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge mclk);
      if (s_awready) s_awvalid <= 1'h0;
      if (s_wready) s_wvalid <= 1'h0;
      if (s_bvalid) break;
    end
    rsp = s_bresp;
    s_bready <= 1'h0;
    if (n == 40) chk(1'h0, 1'h1);
    if (n == 40) test_done();
  endtask

  task automatic rd(input logic [13:0] idx);
    int n;
    @(posedge mclk);
    s_araddr <= {idx, 2'h0};
    s_arvalid <= 1'h1;
    s_rready <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge mclk);
      if (s_arready) s_arvalid <= 1'h0;
      if (s_rvalid) break;
    end
    rdv = s_rdata;
    rsp = s_rresp;
    s_rready <= 1'h0;
    if (n == 40) chk(1'h0, 1'h1);
    if (n == 40) test_done();
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Apply inputs, wait out the two-stage pipeline, judge one output
  task automatic win(input bit rly, input logic [15:0] f, c, input bit e);
    @(posedge mclk);
    op_freq <= f;
    out_current <= c;
    settle(3);
    chk(rly ? relay_out : do_out, e);
  endtask

  // Qualified output must rise no sooner than lo and before hi cycles
  task automatic q_chk(input bit rly, input int lo, input int hi);
    int n;
    for (n = 0; n < hi; n++) begin
      settle(1);
      if ((rly ? relay_out : do_out) === 1'h1) break;
    end
    chk(n >= lo && n < hi, 1'h1);
    if (n == hi) test_done();
  endtask

  task automatic t_reset();
    logic [13:0] ix [10] = '{IDX_DO_SEL, IDX_RLY_SEL, IDX_FRQ_LVL,
      IDX_FRQ_AMP, IDX_ZC_LVL, IDX_ZC_DLY, IDX_OV_THR, IDX_OV_DLY,
      IDX_CR_LVL, IDX_CR_WID};
    logic [15:0] rv [10] = '{RST_DO_SEL, RST_RLY_SEL, RST_FRQ_LVL,
      RST_FRQ_AMP, RST_ZC_LVL, RST_ZC_DLY, RST_OV_THR, RST_OV_DLY,
      RST_CR_LVL, RST_CR_WID};
    foreach (ix[i]) begin
      rd(ix[i]);
      chk(rdv, {16'h0000, rv[i]});
    end
    $display("reset values done");
  endtask

  task automatic t_bus();
    wr(14'h0a50, 16'h0001);
    chk(rsp, RESP_SLVERR);
    rd(14'h0a50);
    chk(rsp, RESP_SLVERR);
    chk(rdv, 32'h0);
    wr(IDX_FRQ_AMP, 16'h07d0);
    rd(IDX_FRQ_AMP);
    chk(rdv, {16'h0000, LIM_PCT100});
    wr(IDX_DO_SEL, 16'h0032);
    rd(IDX_DO_SEL);
    chk(rdv, {16'h0000, LIM_SEL_MAX});
    wr(IDX_FRQ_LVL, 16'hffff);
    rd(IDX_FRQ_LVL);
    chk(rdv, {16'h0000, max_f});
    wr(IDX_FRQ_LVL, RST_FRQ_LVL);
    $display("bus and limits done");
  endtask

  task automatic t_freq();
    logic [15:0] f [4] = '{16'h1770, 16'h1771, 16'h0fa0, 16'h0f9f};
    logic [31:0] hw;
    bit          e;
    wr(IDX_FRQ_AMP, 16'h0064);
    wr(IDX_DO_SEL, FN_FREQ_REACH);
    hw = max_f * 32'h64 / PCT_SCALE;
    foreach (f[i]) begin
      e = f[i] >= RST_FRQ_LVL - hw && f[i] <= RST_FRQ_LVL + hw;
      win(0, f[i], 16'h05dc, e);
    end
    $display("frequency window done");
  endtask

  task automatic t_cur();
    logic [15:0] c [4] = '{16'h044c, 16'h044d, 16'h0384, 16'h0383};
    logic [31:0] lv, hw;
    bit          e;
    wr(IDX_CR_WID, 16'h0064);
    wr(IDX_RLY_SEL, FN_CUR_REACH);
    wr(IDX_DO_SEL, FN_CUR_REACH);
    lv = rat_i * RST_CR_LVL / PCT_SCALE;
    hw = rat_i * 32'h64 / PCT_SCALE;
    foreach (c[i]) begin
      e = c[i] >= lv - hw && c[i] <= lv + hw;
      win(1, 16'h0, c[i], e);
    end
    $display("current window done");
  endtask

  task automatic t_zero();
    logic [7:0] pn;
    logic [15:0] lv;
    wr(IDX_ZC_DLY, 16'h0002);
    wr(IDX_RLY_SEL, FN_ZERO_CUR);
    pn = pulls;
    lv = 16'(rat_i * RST_ZC_LVL / PCT_SCALE);
    @(posedge mclk);
    out_current <= lv;
    q_chk(1, 8, 16);
    win(1, 16'h0, lv + 16'h1, 1'h0);
    chk(pulls, pn + 8'h1);
    chk(rly_on, 1'h0);
    $display("zero current done");
  endtask

  task automatic t_over();
    logic [15:0] th;
    th = 16'(rat_i * RST_OV_THR / PCT_SCALE);
    wr(IDX_DO_SEL, FN_OVER_CUR);
    wr(IDX_RLY_SEL, FN_OVER_CUR);
    win(0, 16'h0, th, 1'h0);
    settle(12);
    chk(do_out, 1'h0);
    @(posedge mclk);
    out_current <= th + 16'h1;
    q_chk(0, 4, 10);
    chk(relay_out, 1'h1);
    win(0, 16'h0, th, 1'h0);
    $display("over limit done");
  endtask

  task automatic t_irq();
    wr(IDX_RLY_SEL, FN_CUR_REACH);
    win(1, 16'h0, 16'h05dc, 1'h0);
    wr(IDX_IRQ_STAT, 16'h000f);
    rd(IDX_IRQ_STAT);
    chk(rdv, 32'h0);
    wr(IDX_IRQ_MASK, 16'h0004);
    win(1, 16'h0, 16'h03e8, 1'h1);
    settle(1);
    chk(irq, 1'h1);
    rd(IDX_IRQ_STAT);
    chk(rdv, 32'h4);
    wr(IDX_IRQ_MASK, 16'h0000);
    settle(2);
    chk(irq, 1'h0);
    wr(IDX_IRQ_MASK, 16'h0004);
    settle(2);
    chk(irq, 1'h1);
    wr(IDX_IRQ_STAT, 16'h0004);
    settle(2);
    chk(irq, 1'h0);
    $display("interrupt done");
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'h0;
    t_reset();
    t_bus();
    t_freq();
    t_cur();
    t_zero();
    t_over();
    t_irq();
    test_done();
  end
endmodule // tb_top
